// [logic/asptb_pkg.sv]
// asptb_pkg: register map, field positions, reset values, clock source
// codes, prescale counts and state encodings of the serial port.
// assumes: imported whole by every design file of the block.
package asptb_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register offsets on the plain register port
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_TIMER_CTRL = 3'h2;
  localparam logic [2:0] ADDR_RELOAD = 3'h3;
  localparam logic [2:0] ADDR_LOW_COUNT = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // serial_control_reg fields
  localparam int BIT_FRAME_WIDTH = 7;
  localparam int BIT_ADDR_MATCH = 5;
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;
  localparam logic UNUSED_BIT_READ = 1'h1;

  // timer control fields
  localparam int BIT_TIMER_RUN = 0;
  localparam int CLK_SEL_LSB = 1;
  localparam int BIT_IRQ_ENABLE = 4;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_CLK_SEL = 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // baud timer clock sources and counts
  typedef enum logic [2:0] {
    CLK_SYS = 3'h0,
    CLK_DIV12 = 3'h1,
    CLK_DIV148 = 3'h2,
    CLK_EXTOSC8 = 3'h3,
    CLK_EXTPIN = 3'h4
  } asptb_clksel_t;

  localparam logic [7:0] PRESCALE_DIV12 = 8'h0C;
  localparam logic [7:0] PRESCALE_DIV148 = 8'h94;
  localparam logic [7:0] PRESCALE_EXTOSC = 8'h08;
  localparam logic [7:0] TIMER_TOP = 8'hFF;

  // bits after the start bit: eight or nine
  localparam logic [3:0] BITS_NARROW = 4'h8;
  localparam logic [3:0] BITS_WIDE = 4'h9;

  ////////////////////////////////////////////////////////////////////////
  // shared frame state, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_START = 2'h1,
    ST_DATA = 2'h3,
    ST_STOP = 2'h2
  } asptb_state_t;

endpackage

// [logic/asptb_baud_timer.sv]
// asptb_baud_timer: 8-bit auto-reload baud timer with its source select,
// plus the hidden receive copy that restarts on demand.
// assumes: clk is the system clock; oscillator and input pins are async.
`timescale 1ns/1ps
`default_nettype none
module asptb_baud_timer
  import asptb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration
  input wire logic timerRun,
  input wire logic [2:0] clkSel,
  input wire logic [7:0] reloadValue,
  input wire logic lowWrite,
  input wire logic [7:0] lowWdata,
  // receive copy restart
  input wire logic rxReload,
  // clock source pins
  input wire logic extOscPin,
  input wire logic extInputPin,
  // counter state and overflow pulses
  output logic [7:0] lowCount,
  output logic txOverflow,
  output logic rxOverflow
);

  logic oscMeta;
  logic oscSync;
  logic oscPrev;
  logic pinMeta;
  logic pinSync;
  logic pinPrev;
  logic [7:0] preCount;
  logic [7:0] rxCount;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, edges taken from the second stage only
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      {oscMeta, oscSync, oscPrev} <= 3'h0;
      {pinMeta, pinSync, pinPrev} <= 3'h0;
    end
    else
    begin
      {oscMeta, oscSync, oscPrev} <= {extOscPin, oscMeta, oscSync};
      {pinMeta, pinSync, pinPrev} <= {extInputPin, pinMeta, pinSync};
    end
  end

  wire oscRise = oscSync & ~oscPrev;
  wire pinRise = pinSync & ~pinPrev;

  wire preStep = (clkSel == CLK_EXTOSC8) ? oscRise : 1'b1;
  wire [7:0] preLimit = (clkSel == CLK_DIV12) ? PRESCALE_DIV12 :
    (clkSel == CLK_DIV148) ? PRESCALE_DIV148 : PRESCALE_EXTOSC;
  wire preWrap = preStep && (preCount == preLimit - 8'h01);
  wire usePre = (clkSel == CLK_DIV12) || (clkSel == CLK_DIV148) ||
    (clkSel == CLK_EXTOSC8);
  wire srcTick = (clkSel == CLK_SYS) ? 1'b1 :
    (clkSel == CLK_EXTPIN) ? pinRise : (usePre && preWrap);
  wire timerTick = timerRun && srcTick;
  wire lowWrap = (lowCount == TIMER_TOP);
  wire rxWrap = (rxCount == TIMER_TOP);

  // prescaler
  always_ff @(posedge clk)
  begin
    if (!resetn)
      preCount <= RESET_BYTE;
    else if (preWrap)
      preCount <= RESET_BYTE;
    else if (preStep)
      preCount <= preCount + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // low counter with auto-reload
  always_ff @(posedge clk)
  begin
    if (!resetn)
      lowCount <= RESET_BYTE;
    else if (lowWrite)
      lowCount <= lowWdata;
    else if (timerTick)
      lowCount <= lowWrap ? reloadValue : lowCount + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      rxCount <= RESET_BYTE;
    else if (rxReload)
      rxCount <= reloadValue;
    else if (timerTick)
      rxCount <= rxWrap ? reloadValue : rxCount + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      txOverflow <= 1'b0;
      rxOverflow <= 1'b0;
    end
    else
    begin
      txOverflow <= timerTick && lowWrap && !lowWrite;
      rxOverflow <= timerTick && rxWrap && !rxReload;
    end
  end

endmodule
`default_nettype wire

// [logic/asptb_serial_port.sv]
// asptb_serial_port: full-duplex asynchronous serial port with control,
// data buffer and baud timer registers on a plain register port.
// assumes: one 40 MHz clock; rx and timer pins arrive asynchronously.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module asptb_serial_port
  import asptb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // serial pins
  input wire logic serialRxPin,
  output logic serialTxPin,
  // baud timer clock pins
  input wire logic extOscPin,
  input wire logic extInputPin,
  // interrupt request
  output logic serialIrq
);

  logic frameWidthSelect;
  logic addrMatchEnable;
  logic rxEnable;
  logic txNinthBit;
  logic rxNinthBit;
  logic txDoneFlag;
  logic rxDoneFlag;
  logic [7:0] rxBuffer;
  logic timerRun;
  logic [2:0] clkSel;
  logic irqEnable;
  logic [7:0] reloadValue;
  logic [7:0] lowCount;
  logic txOverflow;
  logic rxOverflow;
  asptb_state_t txState;
  asptb_state_t rxState;
  logic [7:0] txData;
  logic txPending;
  logic [8:0] txShift;
  logic [3:0] txBitCount;
  logic txHalf;
  logic rxMeta;
  logic rxSync;
  logic rxPrev;
  logic rxReload;
  logic rxPhase;
  logic [8:0] rxShift;
  logic [3:0] rxBitCount;

  ////////////////////////////////////////////////////////////////////////
  // register decode
  wire wrControl = regWr && (regAddr == ADDR_CONTROL);
  wire wrData = regWr && (regAddr == ADDR_DATA);
  wire wrTimerCtrl = regWr && (regAddr == ADDR_TIMER_CTRL);
  wire wrReload = regWr && (regAddr == ADDR_RELOAD);
  wire wrLowCount = regWr && (regAddr == ADDR_LOW_COUNT);
  wire [3:0] frameBits = frameWidthSelect ? BITS_WIDE : BITS_NARROW;

  wire [7:0] controlView = {frameWidthSelect, UNUSED_BIT_READ,
    addrMatchEnable, rxEnable, txNinthBit, rxNinthBit, txDoneFlag,
    rxDoneFlag};
  wire [7:0] timerView = {3'h0, irqEnable, clkSel, timerRun};
  wire [7:0] readMux = (regAddr == ADDR_CONTROL) ? controlView :
    (regAddr == ADDR_DATA) ? rxBuffer :
    (regAddr == ADDR_TIMER_CTRL) ? timerView :
    (regAddr == ADDR_RELOAD) ? reloadValue :
    (regAddr == ADDR_LOW_COUNT) ? lowCount : RESET_BYTE;

  ////////////////////////////////////////////////////////////////////////
  // baud timer and receive copy
  // bit rate is clock over twice (256 minus reload)
  asptb_baud_timer baudTimer (
    .clk(clk),
    .resetn(resetn),
    .timerRun(timerRun),
    .clkSel(clkSel),
    .reloadValue(reloadValue),
    .lowWrite(wrLowCount),
    .lowWdata(regWdata),
    .rxReload(rxReload),
    .extOscPin(extOscPin),
    .extInputPin(extInputPin),
    .lowCount(lowCount),
    .txOverflow(txOverflow),
    .rxOverflow(rxOverflow)
  );

  wire txBitTick = txOverflow && txHalf;
  wire sampleTick = rxOverflow && !rxPhase;

  ////////////////////////////////////////////////////////////////////////
  // transmit control, full duplex
  wire txStartNow = txBitTick && txPending &&
    ((txState == ST_IDLE) || (txState == ST_STOP));
  wire txLastBit = (txBitCount == frameBits);
  wire txDoneSet = txBitTick && (txState == ST_DATA) && txLastBit;

  ////////////////////////////////////////////////////////////////////////
  // receive control
  // start detect on falling edge
  wire rxFall = rxPrev && !rxSync;
  assign rxReload = (rxState == ST_IDLE) && rxEnable && rxFall;
  wire rxNinthIn = frameWidthSelect ? rxShift[8] : rxSync;
  wire rxAccept = !rxDoneFlag && (!addrMatchEnable || rxNinthIn);
  wire rxDoneSet = sampleTick && (rxState == ST_STOP) && rxEnable &&
    rxAccept;
  wire [7:0] rxByte = frameWidthSelect ? rxShift[7:0] : rxShift[8:1];

  wire next_txDoneFlag = txDoneSet |
    (wrControl ? regWdata[BIT_TX_DONE] : txDoneFlag);
  wire next_rxDoneFlag = rxDoneSet |
    (wrControl ? regWdata[BIT_RX_DONE] : rxDoneFlag);

  assign serialIrq = irqEnable && (txDoneFlag || rxDoneFlag);

  ////////////////////////////////////////////////////////////////////////
  // control and timer registers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      {frameWidthSelect, addrMatchEnable, rxEnable, txNinthBit} <= 4'h0;
      {timerRun, irqEnable, clkSel, reloadValue} <= 13'h0000;
    end
    else
    begin
      if (wrControl)
      begin
        frameWidthSelect <= regWdata[BIT_FRAME_WIDTH];
        addrMatchEnable <= regWdata[BIT_ADDR_MATCH];
        rxEnable <= regWdata[BIT_RX_ENABLE];
        txNinthBit <= regWdata[BIT_TX_NINTH];
      end
      if (wrTimerCtrl)
      begin
        timerRun <= regWdata[BIT_TIMER_RUN];
        clkSel <= regWdata[CLK_SEL_LSB +: 3];
        irqEnable <= regWdata[BIT_IRQ_ENABLE];
      end
      if (wrReload)
        reloadValue <= regWdata;
    end
  end

  // flags, receive buffer and registered read data
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      {txDoneFlag, rxDoneFlag, rxNinthBit} <= 3'h0;
      rxBuffer <= RESET_BYTE;
      regRdata <= RESET_BYTE;
    end
    else
    begin
      txDoneFlag <= next_txDoneFlag;
      rxDoneFlag <= next_rxDoneFlag;
      if (rxDoneSet)
      begin
        rxBuffer <= rxByte;
        rxNinthBit <= rxNinthIn;
      end
      else if (wrControl)
        rxNinthBit <= regWdata[BIT_RX_NINTH];
      regRdata <= regRd ? readMux : RESET_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data write queues a transmit byte
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      txData <= RESET_BYTE;
      txPending <= 1'b0;
      txHalf <= 1'b0;
    end
    else
    begin
      if (wrData)
        txData <= regWdata;
      txPending <= wrData | (txPending & ~txStartNow);
      if (txOverflow)
        txHalf <= ~txHalf;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      txState <= ST_IDLE;
      txShift <= 9'h000;
      txBitCount <= 4'h0;
      serialTxPin <= 1'b1;
    end
    else if (txStartNow)
    begin
      txState <= ST_START;
      txShift <= {txNinthBit, txData};
      txBitCount <= 4'h0;
      serialTxPin <= 1'b0;
    end
    else if (txBitTick)
    begin
      case (txState)
        ST_START, ST_DATA:
        begin
          txState <= txLastBit ? ST_STOP : ST_DATA;
          serialTxPin <= txLastBit ? 1'b1 : txShift[0];
          txShift <= {1'b0, txShift[8:1]};
          txBitCount <= txBitCount + 4'h1;
        end
        ST_STOP:
          txState <= ST_IDLE;
        default:
          txState <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rx pin synchroniser, edge taken from the second stage
  always_ff @(posedge clk)
  begin
    if (!resetn)
      {rxMeta, rxSync, rxPrev} <= 3'h7;
    else
      {rxMeta, rxSync, rxPrev} <= {serialRxPin, rxMeta, rxSync};
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rxState <= ST_IDLE;
      rxPhase <= 1'b0;
      rxShift <= 9'h000;
      rxBitCount <= 4'h0;
    end
    else if (!rxEnable)
      rxState <= ST_IDLE;
    else if (rxReload)
    begin
      rxState <= ST_START;
      rxPhase <= 1'b0;
      rxBitCount <= 4'h0;
    end
    else
    begin
      if (rxOverflow)
        rxPhase <= ~rxPhase;
      if (sampleTick)
      begin
        case (rxState)
          ST_START:
            rxState <= rxSync ? ST_IDLE : ST_DATA;
          ST_DATA:
          begin
            rxShift <= {rxSync, rxShift[8:1]};
            rxBitCount <= rxBitCount + 4'h1;
            if (rxBitCount == frameBits - 4'h1)
              rxState <= ST_STOP;
          end
          ST_STOP:
            rxState <= ST_IDLE;
          default:
            rxState <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_tx_start_low: assert property (
    txStartNow |=> !serialTxPin && (txState == ST_START) [*1]
  ) else $error("start bit not driven low");

  a_tx_done_stop: assert property (
    $rose(txDoneFlag) && !$past(wrControl) |->
      (txState == ST_STOP) && serialTxPin
  ) else $error("tx done not at stop bit start");

  a_tx_flag_hold: assert property (
    txDoneFlag && !wrControl |=> txDoneFlag
  ) else $error("tx done cleared by hardware");

  a_rx_flag_hold: assert property (
    rxDoneFlag && !wrControl |=> rxDoneFlag
  ) else $error("rx done cleared by hardware");

  a_irq_on_rx: assert property (
    rxDoneSet && irqEnable && !wrTimerCtrl |=> serialIrq
  ) else $error("no interrupt on receive");

  a_buffer_guard: assert property (
    rxDoneFlag |=> $stable(rxBuffer)
  ) else $error("buffer overwritten while flag set");

  a_read_data: assert property (
    regRd && (regAddr == ADDR_DATA) |=> regRdata == $past(rxBuffer)
  ) else $error("data read not receive buffer");

  a_rx_restart: assert property (
    rxReload |=> (rxState == ST_START) && !rxPhase
  ) else $error("start detect did not restart");

  a_rx_disabled: assert property (
    !rxEnable |=> (rxState == ST_IDLE) &&
      (!$rose(rxDoneFlag) || $past(wrControl))
  ) else $error("receive while disabled");

  a_tx_idle_high: assert property (
    (txState == ST_IDLE) |-> serialTxPin
  ) else $error("idle line not high");

endmodule
`default_nettype wire

// [sim/asptb_remote_uart.sv]
// asptb_remote_uart: far-end serial device; sends frames on demand and
// decodes every frame that appears on its receive line.
// assumes: lines idle high; bitCyc is one bit time in clk cycles.
`timescale 1ns/1ps
`default_nettype none
module asptb_remote_uart
(
  // clock
  input wire logic clk,
  // serial lines
  input wire logic txLine,
  output logic rxLine,
  // frame format, high for nine bits
  input wire logic wideMode
);
  int bitCyc = 8;
  int frameCnt = 0;
  int startLen = 0;
  logic [8:0] lastFrame = 9'h000;
  logic [8:0] shiftIn = 9'h000;

  initial rxLine = 1'b1;

  //////////////////////////////////////////////////////////////////////////
  // start, lsb first, stop
  task automatic send_frame(input logic [8:0] d, input logic stopVal);
    int n;
    n = wideMode ? 9 : 8;
    @(posedge clk);
    rxLine <= 1'b0;
    repeat (bitCyc) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      rxLine <= d[i];
      repeat (bitCyc) @(posedge clk);
    end
    rxLine <= stopVal;
    repeat (bitCyc) @(posedge clk);
    rxLine <= 1'b1;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // mid-bit frame decode
  initial
  begin
    forever
    begin
      @(negedge txLine);
      startLen = 0;
      shiftIn = 9'h000;
      // start length by the clock; a low first data bit leaves it 0
      for (int c = 1; c <= bitCyc; c++)
      begin
        @(posedge clk);
        #1;
        if (startLen == 0 && txLine !== 1'b0)
          startLen = c;
      end
      repeat (bitCyc / 2) @(posedge clk);
      for (int i = 0; i < (wideMode ? 9 : 8); i++)
      begin
        shiftIn[i] = txLine;
        repeat (bitCyc) @(posedge clk);
      end
      lastFrame = shiftIn;
      frameCnt++;
    end
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// tb_top: self-checking bench of the serial port and its baud timer.
// assumes: 40 MHz clock, far end modelled by asptb_remote_uart.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import asptb_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic serialRxPin;
  logic serialTxPin;
  logic extOscPin = 1'b0;
  logic extInputPin = 1'b0;
  logic serialIrq;
  logic wideMode = 1'b0;
  logic [7:0] rd;
  logic [7:0] prevBuf = 8'h00;
  int extDiv = 0;
  int error_cnt = 0;
  int total_checks = 0;

  always #12.5 clk = ~clk;

  // oscillator every 2 cycles, timer pin every 8
  always @(posedge clk)
  begin
    extOscPin <= ~extOscPin;
    extDiv <= extDiv + 1;
    if (extDiv % 4 == 3)
      extInputPin <= ~extInputPin;
  end

  asptb_serial_port asptb_serial_port_inst (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .serialRxPin(serialRxPin), .serialTxPin(serialTxPin),
    .extOscPin(extOscPin), .extInputPin(extInputPin),
    .serialIrq(serialIrq));

  asptb_remote_uart asptb_remote_uart_inst (
    .clk(clk), .txLine(serialTxPin), .rxLine(serialRxPin),
    .wideMode(wideMode));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    rd = regRdata;
  endtask

  task automatic wait_frame(input int n);
    int k;
    k = 0;
    while (asptb_remote_uart_inst.frameCnt < n && k < 8000)
    begin
      @(posedge clk);
      k++;
    end
    check(16'(asptb_remote_uart_inst.frameCnt), 16'(n));
  endtask

  //////////////////////////////////////////////////////////////////////////
  // reset values, unmapped place, read-back
  task automatic t_reset();
    logic [7:0] ex [6] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int a = 0; a < 6; a++)
    begin
      reg_rd(3'(a));
      check(16'(rd), 16'(ex[a]));
    end
    reg_wr(3'h7, 8'hFF);
    reg_rd(ADDR_CONTROL);
    check(16'(rd), 16'h0040);
    reg_wr(ADDR_RELOAD, 8'h5A);
    reg_rd(ADDR_RELOAD);
    check(16'(rd), 16'h005A);
    @(posedge clk);
    #1;
    check(16'(regRdata), 16'h0000);
  endtask

  // start bit length for every clock source
  task automatic t_rates();
    logic [7:0] tc [6] = '{8'h11, 8'h11, 8'h13, 8'h15, 8'h17, 8'h19};
    logic [7:0] rl [6] = '{8'hFE, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    int dv [6] = '{1, 1, 12, 148, 16, 8};
    int n;
    int e;
    for (int i = 0; i < 6; i++)
    begin
      reg_wr(ADDR_RELOAD, rl[i]);
      reg_wr(ADDR_TIMER_CTRL, tc[i]);
      e = 2 * (256 - int'(rl[i])) * dv[i];
      asptb_remote_uart_inst.bitCyc = e;
      n = asptb_remote_uart_inst.frameCnt + 1;
      reg_wr(ADDR_DATA, 8'hA5);
      wait_frame(n);
      check(16'(asptb_remote_uart_inst.startLen), 16'(e));
      check(16'(asptb_remote_uart_inst.lastFrame), 16'h00A5);
      reg_wr(ADDR_CONTROL, 8'h00);
    end
    reg_wr(ADDR_RELOAD, 8'hFC);
    reg_wr(ADDR_TIMER_CTRL, 8'h11);
    asptb_remote_uart_inst.bitCyc = 8;
  endtask

  // done flag at stop start, sticky until cleared
  task automatic t_txflag();
    int n;
    int k;
    k = 0;
    n = asptb_remote_uart_inst.frameCnt + 1;
    reg_wr(ADDR_DATA, 8'h35);
    while (serialIrq !== 1'b1 && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    check(16'(serialTxPin), 16'h0001);
    check(16'(asptb_remote_uart_inst.frameCnt), 16'(n - 1));
    wait_frame(n);
    check(16'(asptb_remote_uart_inst.lastFrame), 16'h0035);
    repeat (40) @(posedge clk);
    check(16'(serialIrq), 16'h0001);
    reg_rd(ADDR_CONTROL);
    check(16'(rd), 16'h0042);
    reg_wr(ADDR_CONTROL, 8'h00);
    @(posedge clk);
    #1;
    check(16'(serialIrq), 16'h0000);
  endtask

  // nine-bit transmit, interrupt masked
  task automatic t_tx9();
    int n;
    reg_wr(ADDR_TIMER_CTRL, 8'h01);
    wideMode <= 1'b1;
    for (int b = 0; b < 2; b++)
    begin
      reg_wr(ADDR_CONTROL, {4'h8, 1'(b), 3'h0});
      n = asptb_remote_uart_inst.frameCnt + 1;
      reg_wr(ADDR_DATA, 8'h35);
      wait_frame(n);
      check(16'(asptb_remote_uart_inst.lastFrame), 16'({1'(b), 8'h35}));
      check(16'(serialIrq), 16'h0000);
      reg_rd(ADDR_CONTROL);
      check(16'(rd), 16'({4'hC, 1'(b), 3'h2}));
    end
    reg_wr(ADDR_TIMER_CTRL, 8'h11);
    wideMode <= 1'b0;
  endtask

  // one received frame and its acceptance
  task automatic t_rx(input logic [7:0] ctrl, input logic [8:0] d,
    input logic stopv, input logic acc);
    logic e9;
    e9 = acc ? (ctrl[7] ? d[8] : stopv) : ctrl[2];
    wideMode <= ctrl[7];
    reg_wr(ADDR_CONTROL, ctrl);
    asptb_remote_uart_inst.send_frame(d, stopv);
    repeat (12) @(posedge clk);
    if (acc)
      prevBuf = d[7:0];
    reg_rd(ADDR_CONTROL);
    check(16'({rd[2], rd[0]}), 16'({e9, acc | ctrl[0]}));
    reg_rd(ADDR_DATA);
    check(16'(rd), 16'(prevBuf));
  endtask

  task automatic t_rxall();
    t_rx(8'h10, 9'h03C, 1'b1, 1'b1);
    t_rx(8'h30, 9'h0C3, 1'b0, 1'b0);
    t_rx(8'h30, 9'h066, 1'b1, 1'b1);
    t_rx(8'hB0, 9'h055, 1'b1, 1'b0);
    t_rx(8'hB0, 9'h1AA, 1'b1, 1'b1);
    t_rx(8'h90, 9'h099, 1'b1, 1'b1);
    t_rx(8'h00, 9'h077, 1'b1, 1'b0);
    t_rx(8'h11, 9'h0EE, 1'b1, 1'b0);
    reg_wr(ADDR_RELOAD, 8'hFF);
    reg_wr(ADDR_TIMER_CTRL, 8'h13);
    asptb_remote_uart_inst.bitCyc = 24;
    t_rx(8'h10, 9'h05A, 1'b1, 1'b1);
    reg_wr(ADDR_RELOAD, 8'hFC);
    reg_wr(ADDR_TIMER_CTRL, 8'h11);
    asptb_remote_uart_inst.bitCyc = 8;
  endtask

  // both directions at once
  task automatic t_duplex();
    int n;
    wideMode <= 1'b0;
    reg_wr(ADDR_CONTROL, 8'h10);
    n = asptb_remote_uart_inst.frameCnt + 1;
    fork
      asptb_remote_uart_inst.send_frame(9'h0C3, 1'b1);
      reg_wr(ADDR_DATA, 8'h5A);
    join
    wait_frame(n);
    check(16'(asptb_remote_uart_inst.lastFrame), 16'h005A);
    repeat (12) @(posedge clk);
    reg_rd(ADDR_DATA);
    check(16'(rd), 16'h00C3);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_rates();
    t_txflag();
    t_tx9();
    t_rxall();
    t_duplex();
    give_verdict();
  end
endmodule
`default_nettype wire
